// ==== sfd_params.svh ====
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH

`define SFD_SPACE_BASE 8'h80
`define SFD_ADDR_ADC_CONTROL 8'h80
`define SFD_ADDR_STACK_POINTER 8'h81
`define SFD_ADDR_DATA_POINTER_LOW 8'h82
`define SFD_ADDR_DATA_POINTER_HIGH 8'h83
`define SFD_ADDR_FLASH_ADDRESS_LOW 8'h84
`define SFD_ADDR_FLASH_ADDRESS_HIGH 8'h85
`define SFD_ADDR_FLASH_CTRL_STATUS 8'h86
`define SFD_ADDR_POWER_CONTROL 8'h87
`define SFD_ADDR_TIMER01_CONTROL 8'h88
`define SFD_ADDR_TIMER01_MODE 8'h89
`define SFD_ADDR_TIMER_A_COUNT_LOW 8'h8A
`define SFD_ADDR_TIMER_B_COUNT_LOW 8'h8B
`define SFD_ADDR_TIMER_A_COUNT_HIGH 8'h8C
`define SFD_ADDR_TIMER_B_COUNT_HIGH 8'h8D
`define SFD_ADDR_FLASH_DATA_LOW 8'h8E
`define SFD_ADDR_FLASH_DATA_HIGH 8'h8F
`define SFD_ADDR_UNLOCK_ID 8'hA1
`define SFD_ADDR_WAKE_CONTROL 8'hA9
`define SFD_ADDR_GLOBAL_CONFIG 8'hB1
`define SFD_ADDR_CLOCK_CONFIG 8'hB9
`define SFD_ADDR_SERIAL_CLK_DIV 8'hFB

`define SFD_RST_STACK_POINTER 8'h07
`define SFD_RST_POWER_CONTROL 8'h10
`define SFD_RST_GLOBAL_CONFIG 8'h80
`define SFD_RST_CLOCK_CONFIG 8'h83
`define SFD_RST_ZERO 8'h00

`define SFD_UNLOCK_KEY1 8'h55
`define SFD_UNLOCK_KEY2 8'hAA
`define SFD_SAFE_WINDOW_CYCLES 8'h40
`define SFD_PART_ID_VALUE 8'h3C

`endif

// ==== sfd_pkg.sv ====
package sfd_pkg;
    typedef enum logic [2:0] {
        SFD_LOCKED = 3'b001,
        SFD_KEY1_SEEN = 3'b010,
        SFD_SAFE = 3'b100
    } sfd_unlock_t;

    typedef enum logic [1:0] {
        SFD_ACC_BYTE = 2'b00,
        SFD_ACC_BIT_WRITE = 2'b01,
        SFD_ACC_BIT_READ = 2'b10
    } sfd_access_t;
endpackage : sfd_pkg

// ==== sfd_reg_mem.sv ====
`timescale 1ns/1ps
// sixteen general byte registers; read data is registered
module sfd_reg_mem (
    input wire logic clock,
    input wire logic rst,
    input wire logic writeEnable,
    input wire logic [3:0] writeIndex,
    input wire logic [7:0] writeData,
    input wire logic [3:0] readIndex,
    output logic [7:0] readData
);
    `include "sfd_params.svh"
    logic [7:0] store [0:15];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                store[i] <= `SFD_RST_ZERO;
            end
            store[1] <= `SFD_RST_STACK_POINTER;
            store[7] <= `SFD_RST_POWER_CONTROL;
        end else if (writeEnable) begin
            store[writeIndex] <= writeData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readData <= `SFD_RST_ZERO;
        end else begin
            readData <= store[readIndex];
        end
    end
endmodule : sfd_reg_mem

// ==== sfd_unlock.sv ====
`timescale 1ns/1ps
// two-key unlock sequence opening a bounded safe-mode window
module sfd_unlock (
    input wire logic clock,
    input wire logic rst,
    input wire logic keyWrite,
    input wire logic [7:0] keyData,
    output logic safeMode
);
    import sfd_pkg::*;
    `include "sfd_params.svh"
    sfd_unlock_t state;
    logic [7:0] windowCount;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SFD_LOCKED;
            windowCount <= 8'h00;
        end else begin
            case (state)
                SFD_LOCKED: begin
                    if (keyWrite && keyData == `SFD_UNLOCK_KEY1) begin
                        state <= SFD_KEY1_SEEN;
                    end
                end
                SFD_KEY1_SEEN: begin
                    if (keyWrite) begin
                        state <= (keyData == `SFD_UNLOCK_KEY2) ? SFD_SAFE : SFD_LOCKED;
                        windowCount <= `SFD_SAFE_WINDOW_CYCLES;
                    end
                end
                SFD_SAFE: begin
                    // the window closes by itself so a stray write later stays blocked
                    if (windowCount == 8'h01) begin
                        state <= SFD_LOCKED;
                    end
                    windowCount <= windowCount - 8'h01;
                end
                default: state <= SFD_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            safeMode <= 1'b0;
        end else begin
            safeMode <= (state == SFD_SAFE) && (windowCount != 8'h01);
        end
    end
endmodule : sfd_unlock

// ==== sfd_decoder.sv ====
`timescale 1ns/1ps
module sfd_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic accessValid,
    input wire logic directMode,
    input wire sfd_pkg::sfd_access_t accessKind,
    input wire logic writeEnable,
    input wire logic [7:0] address,
    input wire logic [2:0] bitSelect,
    input wire logic [7:0] writeData,
    input wire logic [7:0] flashStatus,
    output logic [7:0] readData,
    output logic readValid,
    output logic [7:0] flashControl,
    output logic flashControlStrobe,
    output logic [7:0] globalConfig,
    output logic [7:0] clockConfig,
    output logic [7:0] wakeControl,
    output logic [7:0] serialClockDivider,
    output logic safeModeActive
);
    import sfd_pkg::*;
    `include "sfd_params.svh"

    function automatic logic bitAddressable(input logic [7:0] addr);
        return addr[2:0] == 3'b000;
    endfunction : bitAddressable

    function automatic logic [7:0] mergeBit(input logic [7:0] old, input logic [2:0] pos,
                                            input logic val);
        logic [7:0] result;
        result = old;
        result[pos] = val;
        return result;
    endfunction : mergeBit

    logic inSpace;
    logic legal;
    logic isBitWrite;
    logic isBitRead;
    logic doWrite;
    logic doRead;
    logic inLowBank;
    logic [7:0] memRead;
    logic [7:0] currentByte;
    logic [7:0] next_byte;
    logic safeMode;
    logic memWrite;
    logic [7:0] readAddr;
    logic [2:0] readBit;
    sfd_access_t readKind;
    logic readPending;

    assign inSpace = address[7] == 1'b1;
    assign isBitWrite = accessKind == SFD_ACC_BIT_WRITE;
    assign isBitRead = accessKind == SFD_ACC_BIT_READ;
    // bit accesses to non-multiple-of-eight addresses are dropped, not remapped
    assign legal = accessValid && directMode && inSpace
                   && (accessKind == SFD_ACC_BYTE || bitAddressable(address));
    assign doWrite = legal && writeEnable && !isBitRead;
    assign doRead = legal && !writeEnable;
    assign inLowBank = address[7:4] == 4'h8;

    // byte currently held at the addressed location, used for bit merges
    always_comb begin
        case (address)
            `SFD_ADDR_GLOBAL_CONFIG: currentByte = globalConfig;
            `SFD_ADDR_CLOCK_CONFIG: currentByte = clockConfig;
            `SFD_ADDR_WAKE_CONTROL: currentByte = wakeControl;
            `SFD_ADDR_SERIAL_CLK_DIV: currentByte = serialClockDivider;
            default: currentByte = memRead;
        endcase
    end

    // bit write merges into the live byte so neighbouring bits stay put
    always_comb begin
        if (isBitWrite) begin
            next_byte = mergeBit(currentByte, bitSelect, writeData[0]);
        end else begin
            next_byte = writeData;
        end
    end

    // the memory read port follows the bus address so bit merges see current data;
    // a bit write must therefore be issued one cycle after the address settles
    assign memWrite = doWrite && inLowBank && address != `SFD_ADDR_FLASH_CTRL_STATUS;

    sfd_reg_mem u_mem (
        .clock(clock),
        .rst(rst),
        .writeEnable(memWrite),
        .writeIndex(address[3:0]),
        .writeData(next_byte),
        .readIndex(address[3:0]),
        .readData(memRead)
    );

    sfd_unlock u_unlock (
        .clock(clock),
        .rst(rst),
        .keyWrite(doWrite && address == `SFD_ADDR_UNLOCK_ID),
        .keyData(writeData),
        .safeMode(safeMode)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            safeModeActive <= 1'b0;
        end else begin
            safeModeActive <= safeMode;
        end
    end

    // protected configuration; locked writes simply vanish
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            globalConfig <= `SFD_RST_GLOBAL_CONFIG;
            clockConfig <= `SFD_RST_CLOCK_CONFIG;
            wakeControl <= `SFD_RST_ZERO;
        end else if (doWrite && safeMode) begin
            case (address)
                `SFD_ADDR_GLOBAL_CONFIG: globalConfig <= next_byte;
                `SFD_ADDR_CLOCK_CONFIG: clockConfig <= next_byte;
                `SFD_ADDR_WAKE_CONTROL: wakeControl <= next_byte;
                default: ;
            endcase
        end
    end

    // the serial clock divider and slave preload are two names for this one byte
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serialClockDivider <= `SFD_RST_ZERO;
        end else if (doWrite && address == `SFD_ADDR_SERIAL_CLK_DIV) begin
            serialClockDivider <= next_byte;
        end
    end

    // write side of the shared flash address, held apart from the status input
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flashControl <= `SFD_RST_ZERO;
            flashControlStrobe <= 1'b0;
        end else begin
            flashControlStrobe <= doWrite && address == `SFD_ADDR_FLASH_CTRL_STATUS;
            if (doWrite && address == `SFD_ADDR_FLASH_CTRL_STATUS) begin
                flashControl <= writeData;
            end
        end
    end

    // read capture: memory data arrive one cycle after the address, so hold the
    // request for one cycle and assemble the answer then
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readPending <= 1'b0;
            readAddr <= 8'h00;
            readBit <= 3'b000;
            readKind <= SFD_ACC_BYTE;
        end else begin
            readPending <= doRead;
            if (doRead) begin
                readAddr <= address;
                readBit <= bitSelect;
                readKind <= accessKind;
            end
        end
    end

    logic [7:0] readByte;
    always_comb begin
        case (readAddr)
            `SFD_ADDR_FLASH_CTRL_STATUS: readByte = flashStatus;
            `SFD_ADDR_UNLOCK_ID: readByte = `SFD_PART_ID_VALUE;
            `SFD_ADDR_GLOBAL_CONFIG: readByte = globalConfig;
            `SFD_ADDR_CLOCK_CONFIG: readByte = clockConfig;
            `SFD_ADDR_WAKE_CONTROL: readByte = wakeControl;
            `SFD_ADDR_SERIAL_CLK_DIV: readByte = serialClockDivider;
            default: begin
                if (readAddr[7:4] == 4'h8) begin
                    readByte = memRead;
                end else begin
                    readByte = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readData <= 8'h00;
            readValid <= 1'b0;
        end else begin
            readValid <= readPending;
            if (readPending) begin
                if (readKind == SFD_ACC_BIT_READ) begin
                    readData <= {7'b0000000, readByte[readBit]};
                end else begin
                    readData <= readByte;
                end
            end
        end
    end
endmodule : sfd_decoder

// ==== sfd_cpu_model.sv ====
`timescale 1ns/1ps
// core side: address and kind are set up a cycle before the pulse so bit merges see them
module sfd_cpu_model (
    input wire logic clock,
    output logic accessValid,
    output logic directMode,
    output sfd_pkg::sfd_access_t accessKind,
    output logic writeEnable,
    output logic [7:0] address,
    output logic [2:0] bitSelect,
    output logic [7:0] writeData,
    input wire logic [7:0] readData,
    input wire logic readValid
);
    import sfd_pkg::*;
    initial begin
        accessValid = 1'b0;
        directMode = 1'b1;
        accessKind = SFD_ACC_BYTE;
        writeEnable = 1'b0;
        address = 8'h00;
        bitSelect = 3'h0;
        writeData = 8'h00;
    end
    task automatic acc(input sfd_access_t k, input logic w, input logic [7:0] a,
            input logic [2:0] b, input logic [7:0] d, input logic dm);
        @(posedge clock);
        accessKind <= k;
        writeEnable <= w;
        address <= a;
        bitSelect <= b;
        writeData <= d;
        directMode <= dm;
        @(posedge clock);
        accessValid <= 1'b1;
        @(posedge clock);
        accessValid <= 1'b0;
        // released address and data lines show a changed pattern, never the last value
        address <= ~a;
        writeData <= ~d;
    endtask : acc
    // waits a fixed four cycles, so an absent answer is seen as ok low
    task automatic rd(input sfd_access_t k, input logic [7:0] a, input logic [2:0] b,
            input logic dm, output logic [7:0] q, output bit ok);
        ok = 1'b0;
        q = 8'h00;
        acc(k, 1'b0, a, b, 8'h00, dm);
        repeat (4) begin
            @(posedge clock);
            #1;
            if (readValid === 1'b1 && !ok) begin
                q = readData;
                ok = 1'b1;
            end
        end
    endtask : rd
endmodule : sfd_cpu_model

// ==== sfd_decoder_checker.sv ====
`timescale 1ns/1ps
`include "sfd_params.svh"
module sfd_decoder_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic accessValid,
    input wire logic directMode,
    input wire sfd_pkg::sfd_access_t accessKind,
    input wire logic writeEnable,
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic [7:0] flashStatus,
    input wire logic [7:0] readData,
    input wire logic readValid,
    input wire logic [7:0] flashControl,
    input wire logic flashControlStrobe,
    input wire logic [7:0] globalConfig,
    input wire logic safeModeActive
);
    import sfd_pkg::*;
    logic req, rdb, wrb, rdReq;
    assign req = accessValid && directMode && address[7];
    assign rdReq = req && !writeEnable;
    assign rdb = req && !writeEnable && accessKind == SFD_ACC_BYTE;
    assign wrb = req && writeEnable && accessKind == SFD_ACC_BYTE;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_READ_LATENCY: assert property (rdb |-> ##2 readValid)
        else $error("byte read not answered");
    AST_NO_SPURIOUS: assert property (readValid |-> $past(rdReq, 2))
        else $error("read answer without a request");
    AST_OUT_OF_SPACE: assert property ((accessValid && (!address[7] || !directMode))
        |-> ##2 !readValid)
        else $error("low or indirect access answered");
    AST_BIT_REFUSED: assert property ((req && accessKind != SFD_ACC_BYTE
        && address[2:0] != 3'h0) |-> ##2 !readValid)
        else $error("bit access honoured off a multiple of eight");
    AST_BIT_READ: assert property ((req && !writeEnable && accessKind == SFD_ACC_BIT_READ
        && address[2:0] == 3'h0) |-> ##2 readValid && readData[7:1] == 7'h00)
        else $error("bit read answer malformed");
    AST_PROTECT: assert property ((wrb && address == `SFD_ADDR_GLOBAL_CONFIG)
        ##1 !safeModeActive |-> $stable(globalConfig))
        else $error("protected write taken outside safe mode");
    AST_FLASH_CTRL: assert property ((wrb && address == `SFD_ADDR_FLASH_CTRL_STATUS)
        |=> flashControlStrobe && flashControl == $past(writeData))
        else $error("flash control write lost");
    AST_PART_ID: assert property ((rdb && address == `SFD_ADDR_UNLOCK_ID)
        |-> ##2 readData == `SFD_PART_ID_VALUE)
        else $error("identity read wrong");
    AST_STATUS: assert property ((rdb && address == `SFD_ADDR_FLASH_CTRL_STATUS)
        ##1 $stable(flashStatus) ##1 $stable(flashStatus) |-> readData == flashStatus)
        else $error("shared address read not from status");
    AST_UNMAPPED: assert property ((rdb && address[7:4] == 4'h9)
        |-> ##2 readData == 8'h00)
        else $error("unmapped read not zero");
    cover property (wrb && address == `SFD_ADDR_GLOBAL_CONFIG && safeModeActive);
    cover property (wrb && address == `SFD_ADDR_FLASH_CTRL_STATUS);
    cover property (req && accessKind == SFD_ACC_BIT_WRITE && address[2:0] == 3'h0);
endmodule : sfd_decoder_checker
bind sfd_decoder sfd_decoder_checker chk (.*);

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "sfd_params.svh"
module testbench;
    import sfd_pkg::*;
    logic clock, rst, accessValid, directMode, writeEnable, readValid;
    logic flashControlStrobe, safeModeActive;
    sfd_access_t accessKind;
    logic [7:0] address, writeData, flashStatus, readData, flashControl;
    logic [7:0] globalConfig, clockConfig, wakeControl, serialClockDivider;
    logic [2:0] bitSelect;
    logic [7:0] mdl [256];
    logic [7:0] q;
    logic [7:0] prot [3] = '{`SFD_ADDR_GLOBAL_CONFIG, `SFD_ADDR_CLOCK_CONFIG,
        `SFD_ADDR_WAKE_CONTROL};
    bit ok;
    int n_errors, n_checks, i;
    sfd_decoder dut (.*);
    sfd_cpu_model cpu (.*);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chkf(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask : chkf
    task automatic rdchk(input logic [7:0] a);
        cpu.rd(SFD_ACC_BYTE, a, 3'h0, 1'b1, q, ok);
        chkf(ok, 1'b1);
        chk8(q, mdl[a]);
    endtask : rdchk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.acc(SFD_ACC_BYTE, 1'b1, a, 3'h0, d, 1'b1);
    endtask : wr
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        give_verdict;
    end
    initial begin
        rst = 1'b1;
        void'($urandom(70));
        q = $urandom;
        flashStatus = q;
        foreach (mdl[j]) mdl[j] = 8'h00;
        mdl[8'h81] = `SFD_RST_STACK_POINTER;
        mdl[8'h87] = `SFD_RST_POWER_CONTROL;
        mdl[8'hB1] = `SFD_RST_GLOBAL_CONFIG;
        mdl[8'hB9] = `SFD_RST_CLOCK_CONFIG;
        mdl[8'hA1] = `SFD_PART_ID_VALUE;
        mdl[8'h86] = q;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk8(globalConfig, mdl[8'hB1]);
        chk8(clockConfig, mdl[8'hB9]);
        for (i = 8'h80; i < 8'h90; i++) begin
            if (i != 8'h86) begin
                rdchk(i[7:0]);
                mdl[i] = $urandom;
                wr(i[7:0], mdl[i]);
                rdchk(i[7:0]);
            end
        end
        for (i = 0; i < 8; i++) begin
            cpu.acc(SFD_ACC_BIT_WRITE, 1'b1, 8'h80, i[2:0], {7'h00, ~mdl[8'h80][i]}, 1'b1);
            mdl[8'h80][i] = ~mdl[8'h80][i];
            rdchk(8'h80);
            cpu.rd(SFD_ACC_BIT_READ, 8'h88, i[2:0], 1'b1, q, ok);
            chk8(q, {7'h00, mdl[8'h88][i]});
        end
        cpu.acc(SFD_ACC_BIT_WRITE, 1'b1, 8'h81, ~mdl[8'h81][2:0], 8'h01, 1'b1);
        rdchk(8'h81);
        cpu.rd(SFD_ACC_BIT_READ, 8'h81, 3'h1, 1'b1, q, ok);
        chkf(ok, 1'b0);
        cpu.rd(SFD_ACC_BYTE, 8'h82, 3'h0, 1'b0, q, ok);
        chkf(ok, 1'b0);
        cpu.rd(SFD_ACC_BYTE, 8'h02, 3'h0, 1'b1, q, ok);
        chkf(ok, 1'b0);
        cpu.acc(SFD_ACC_BYTE, 1'b1, 8'h82, 3'h0, ~mdl[8'h82], 1'b0);
        rdchk(8'h82);
        wr(8'h95, 8'h5A);
        rdchk(8'h95);
        wr(`SFD_ADDR_GLOBAL_CONFIG, ~mdl[8'hB1]);
        rdchk(`SFD_ADDR_GLOBAL_CONFIG);
        wr(`SFD_ADDR_UNLOCK_ID, `SFD_UNLOCK_KEY1);
        wr(`SFD_ADDR_UNLOCK_ID, `SFD_UNLOCK_KEY2);
        for (i = 0; i < 10 && safeModeActive !== 1'b1; i++) @(posedge clock);
        chkf(safeModeActive, 1'b1);
        foreach (prot[j]) begin
            mdl[prot[j]] = $urandom;
            wr(prot[j], mdl[prot[j]]);
            rdchk(prot[j]);
        end
        chk8(globalConfig, mdl[8'hB1]);
        chk8(clockConfig, mdl[8'hB9]);
        chk8(wakeControl, mdl[8'hA9]);
        rdchk(`SFD_ADDR_UNLOCK_ID);
        wr(`SFD_ADDR_FLASH_CTRL_STATUS, 8'hC3);
        #1;
        chkf(flashControlStrobe, 1'b1);
        chk8(flashControl, 8'hC3);
        // only the status side is read back: the written control byte never reaches the read data
        rdchk(`SFD_ADDR_FLASH_CTRL_STATUS);
        mdl[8'hFB] = $urandom;
        wr(`SFD_ADDR_SERIAL_CLK_DIV, mdl[8'hFB]);
        rdchk(`SFD_ADDR_SERIAL_CLK_DIV);
        chk8(serialClockDivider, mdl[8'hFB]);
        repeat (70) @(posedge clock);
        wr(`SFD_ADDR_CLOCK_CONFIG, ~mdl[8'hB9]);
        rdchk(`SFD_ADDR_CLOCK_CONFIG);
        give_verdict;
    end
endmodule : testbench
